// File: power_monitor_warn_limits.sv
// Contract
// - capability byte reads fixed feature value
// - limits served by read/write word
// - overcurrent compares current magnitude, both signs
// - overcurrent sets summary, word, iout, input bits
// - overcurrent field bits 14:3, others zero
// - overcurrent limit resets to all ones
// - overvoltage sets summary, input, warning flag
// - overvoltage alert suppressed by its mask
// - voltage limits share 1.25 mV scaling
// - voltage limit fields bits 14:3, others zero
// - overvoltage limit resets to all ones
// - undervoltage limit resets to zero
// - undervoltage sets summary, input, warning flag
// - overpower compares calculated power result
// - overpower sets input bits, maskable alert
// - overpower field bits 15:4, resets ones
// - clear faults drops flags, they re-arm
// - summary bit is OR of oc, ov, uv warnings
`timescale 1ns/1ns
module power_monitor_warn_limits (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// link pins
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda,
	output logic o_sda_oe_n,
	// alert pin
	output logic o_alert,
	output logic o_alert_oe_n,
	// measurements and mask
	input pmon_pkg::meas_s i_meas,
	input wire logic [7:0] i_warning_alert_mask,
	// status view
	output pmon_pkg::status_s o_status
);

	// ==========================================================
	// pin synchronisers
	logic scl_meta_reg;
	logic scl_sync_reg;
	logic scl_prev_reg;
	logic sda_meta_reg;
	logic sda_sync_reg;
	logic sda_prev_reg;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			scl_meta_reg <= 1'b1;
			scl_sync_reg <= 1'b1;
			scl_prev_reg <= 1'b1;
			sda_meta_reg <= 1'b1;
			sda_sync_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end else begin
			scl_meta_reg <= i_scl;
			scl_sync_reg <= scl_meta_reg;
			scl_prev_reg <= scl_sync_reg;
			sda_meta_reg <= i_sda;
			sda_sync_reg <= sda_meta_reg;
			sda_prev_reg <= sda_sync_reg;
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;

	assign scl_rise = scl_sync_reg & ~scl_prev_reg;
	assign scl_fall = ~scl_sync_reg & scl_prev_reg;
	assign start_seen = scl_sync_reg & scl_prev_reg & sda_prev_reg & ~sda_sync_reg;
	assign stop_seen = scl_sync_reg & scl_prev_reg & ~sda_prev_reg & sda_sync_reg;

	// ==========================================================
	// limit registers
	logic [15:0] oc_limit_reg;
	logic [15:0] ov_limit_reg;
	logic [15:0] uv_limit_reg;
	logic [15:0] op_limit_reg;
	logic wr_commit;
	logic [7:0] cmd_reg;
	logic [7:0] wlow_reg;
	logic [7:0] shift_reg;
	logic [15:0] wr_word;

	assign wr_word = {shift_reg, wlow_reg};

	// word writes land on the limits
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			oc_limit_reg <= pmon_pkg::OVERCURRENT_RESET;
			ov_limit_reg <= pmon_pkg::OVERVOLTAGE_RESET;
			uv_limit_reg <= pmon_pkg::UNDERVOLTAGE_RESET;
			op_limit_reg <= pmon_pkg::OVERPOWER_RESET;
		end else if (wr_commit) begin
			case (cmd_reg)
				pmon_pkg::CMD_OVERCURRENT_THRESHOLD: begin
					oc_limit_reg <= wr_word & pmon_pkg::CURRENT_FIELD_MASK;
				end
				pmon_pkg::CMD_OVERVOLTAGE_THRESHOLD: begin
					ov_limit_reg <= wr_word & pmon_pkg::VOLTAGE_FIELD_MASK;
				end
				pmon_pkg::CMD_UNDERVOLTAGE_THRESHOLD: begin
					uv_limit_reg <= wr_word & pmon_pkg::VOLTAGE_FIELD_MASK;
				end
				pmon_pkg::CMD_OVERPOWER_THRESHOLD: begin
					op_limit_reg <= wr_word & pmon_pkg::POWER_FIELD_MASK;
				end
				default: begin
				end
			endcase
		end
	end

	// ==========================================================
	// read data selection
	function automatic logic [7:0] read_byte(input logic [7:0] cmd, input logic hi,
		input logic [15:0] oc, input logic [15:0] ov, input logic [15:0] uv,
		input logic [15:0] op);
		logic [15:0] word;
		word = 16'h0000;
		read_byte = pmon_pkg::UNMAPPED_READ;
		case (cmd)
			pmon_pkg::CMD_OVERCURRENT_THRESHOLD: word = oc;
			pmon_pkg::CMD_OVERVOLTAGE_THRESHOLD: word = ov;
			pmon_pkg::CMD_UNDERVOLTAGE_THRESHOLD: word = uv;
			pmon_pkg::CMD_OVERPOWER_THRESHOLD: word = op;
			default: word = 16'h0000;
		endcase
		if (cmd == pmon_pkg::CMD_SUPPORTED_FEATURES) begin
			read_byte = hi ? pmon_pkg::UNMAPPED_READ : pmon_pkg::SUPPORTED_FEATURES_VALUE;
		end else begin
			// low byte first, as a read word sends it
			read_byte = hi ? word[15:8] : word[7:0];
		end
	endfunction : read_byte

	// ==========================================================
	// link engine
	pmon_pkg::link_state_e state_reg;
	logic [3:0] bit_cnt_reg;
	logic [1:0] byte_idx_reg;
	logic rw_reg;
	logic [7:0] tx_reg;
	logic sda_low_reg;
	logic clear_pulse_reg;
	logic [7:0] rd_lo;
	logic [7:0] rd_hi;

	assign rd_lo = read_byte(cmd_reg, 1'b0, oc_limit_reg, ov_limit_reg, uv_limit_reg,
		op_limit_reg);
	assign rd_hi = read_byte(cmd_reg, 1'b1, oc_limit_reg, ov_limit_reg, uv_limit_reg,
		op_limit_reg);

	assign wr_commit = scl_fall && (state_reg == pmon_pkg::ST_WDATA) &&
		(bit_cnt_reg == 4'h8) && (byte_idx_reg == 2'h1);

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state_reg <= pmon_pkg::ST_IDLE;
			bit_cnt_reg <= 4'h0;
			byte_idx_reg <= 2'h0;
			rw_reg <= 1'b0;
			cmd_reg <= 8'h00;
			wlow_reg <= 8'h00;
			shift_reg <= 8'h00;
			tx_reg <= 8'h00;
			sda_low_reg <= 1'b0;
			clear_pulse_reg <= 1'b0;
		end else begin
			clear_pulse_reg <= 1'b0;
			if (start_seen) begin
				state_reg <= pmon_pkg::ST_ADDR;
				bit_cnt_reg <= 4'h0;
				sda_low_reg <= 1'b0;
			end else if (stop_seen) begin
				state_reg <= pmon_pkg::ST_IDLE;
				sda_low_reg <= 1'b0;
			end else if (scl_rise) begin
				case (state_reg)
					pmon_pkg::ST_ADDR, pmon_pkg::ST_CMD, pmon_pkg::ST_WDATA: begin
						shift_reg <= {shift_reg[6:0], sda_sync_reg};
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end
					pmon_pkg::ST_RDATA_ACK: begin
						// master nack ends the read
						if (sda_sync_reg) begin
							state_reg <= pmon_pkg::ST_IDLE;
						end
					end
					default: begin
					end
				endcase
			end else if (scl_fall) begin
				case (state_reg)
					pmon_pkg::ST_ADDR: begin
						if (bit_cnt_reg == 4'h8) begin
							if (shift_reg[7:1] == pmon_pkg::DEVICE_ADDR) begin
								state_reg <= pmon_pkg::ST_ADDR_ACK;
								rw_reg <= shift_reg[0];
								sda_low_reg <= 1'b1;
							end else begin
								state_reg <= pmon_pkg::ST_IDLE;
							end
						end
					end
					pmon_pkg::ST_ADDR_ACK: begin
						bit_cnt_reg <= 4'h0;
						byte_idx_reg <= 2'h0;
						if (rw_reg) begin
							// first byte of a read word
							tx_reg <= rd_lo;
							sda_low_reg <= ~rd_lo[7];
							bit_cnt_reg <= 4'h1;
							state_reg <= pmon_pkg::ST_RDATA;
						end else begin
							sda_low_reg <= 1'b0;
							state_reg <= pmon_pkg::ST_CMD;
						end
					end
					pmon_pkg::ST_CMD: begin
						if (bit_cnt_reg == 4'h8) begin
							cmd_reg <= shift_reg;
							sda_low_reg <= 1'b1;
							state_reg <= pmon_pkg::ST_CMD_ACK;
							clear_pulse_reg <= (shift_reg == pmon_pkg::CMD_CLEAR_FAULTS);
						end
					end
					pmon_pkg::ST_CMD_ACK, pmon_pkg::ST_WDATA_ACK: begin
						sda_low_reg <= 1'b0;
						bit_cnt_reg <= 4'h0;
						state_reg <= pmon_pkg::ST_WDATA;
					end
					pmon_pkg::ST_WDATA: begin
						if (bit_cnt_reg == 4'h8) begin
							// extra bytes such as a check byte are acked and dropped
							if (byte_idx_reg == 2'h0) begin
								wlow_reg <= shift_reg;
							end
							if (byte_idx_reg != 2'h3) begin
								byte_idx_reg <= byte_idx_reg + 2'h1;
							end
							sda_low_reg <= 1'b1;
							state_reg <= pmon_pkg::ST_WDATA_ACK;
						end
					end
					pmon_pkg::ST_RDATA: begin
						if (bit_cnt_reg == 4'h8) begin
							sda_low_reg <= 1'b0;
							state_reg <= pmon_pkg::ST_RDATA_ACK;
						end else begin
							sda_low_reg <= ~tx_reg[6];
							tx_reg <= {tx_reg[6:0], 1'b0};
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
						end
					end
					pmon_pkg::ST_RDATA_ACK: begin
						// second byte is the high half
						tx_reg <= rd_hi;
						sda_low_reg <= ~rd_hi[7];
						bit_cnt_reg <= 4'h1;
						byte_idx_reg <= 2'h1;
						state_reg <= pmon_pkg::ST_RDATA;
					end
					default: begin
						state_reg <= pmon_pkg::ST_IDLE;
					end
				endcase
			end
		end
	end

	// open drain: only ever pulls low
	assign o_sda = 1'b0;
	assign o_sda_oe_n = ~sda_low_reg;

	// ==========================================================
	// limit comparison
	logic [15:0] current_mag;
	logic oc_cross;
	logic ov_cross;
	logic uv_cross;
	logic op_cross;

	assign current_mag = i_meas.current_reading[15] ?
		(~i_meas.current_reading + 16'h0001) : i_meas.current_reading;
	// limit and reading share weighting, compared directly
	assign oc_cross = i_meas.current_valid && (current_mag > oc_limit_reg);
	// same 1.25 mV code for reading and limit
	assign ov_cross = i_meas.voltage_valid &&
		(i_meas.bus_voltage_reading > ov_limit_reg);
	assign uv_cross = i_meas.voltage_valid &&
		(i_meas.bus_voltage_reading < uv_limit_reg);
	// calculated power, not a raw sample
	assign op_cross = i_meas.power_valid && (i_meas.power_reading > op_limit_reg);

	// ==========================================================
	// warning flags
	logic oc_flag;
	logic ov_flag;
	logic uv_flag;
	logic op_flag;

	warn_flag u_oc_flag (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_set(oc_cross),
		.i_clear(clear_pulse_reg),
		.o_flag(oc_flag)
	);
	warn_flag u_ov_flag (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_set(ov_cross),
		.i_clear(clear_pulse_reg),
		.o_flag(ov_flag)
	);
	warn_flag u_uv_flag (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_set(uv_cross),
		.i_clear(clear_pulse_reg),
		.o_flag(uv_flag)
	);
	warn_flag u_op_flag (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_set(op_cross),
		.i_clear(clear_pulse_reg),
		.o_flag(op_flag)
	);

	// ==========================================================
	// status and alert
	pmon_pkg::status_s status_next;
	logic alert_next;
	logic alert_reg;

	always_comb begin
		status_next = '0;
		// summary is OR of the oc, ov and uv warnings
		status_next.status_byte[pmon_pkg::STATUS_BYTE_NOTA] = oc_flag | ov_flag | uv_flag;
		status_next.status_word[pmon_pkg::STATUS_WORD_IOUT] = oc_flag;
		status_next.status_iout[pmon_pkg::STATUS_IOUT_OC_WARN] = oc_flag;
		status_next.status_input[pmon_pkg::STATUS_INPUT_OC_WARN] = oc_flag;
		status_next.status_input[pmon_pkg::STATUS_INPUT_OV_WARN] = ov_flag;
		status_next.status_input[pmon_pkg::STATUS_INPUT_UV_WARN] = uv_flag;
		status_next.status_input[pmon_pkg::STATUS_INPUT_OP_WARN] = op_flag;
		status_next.status_word[pmon_pkg::STATUS_WORD_INPUT] =
			oc_flag | ov_flag | uv_flag | op_flag;
		status_next.status_word[7:0] = status_next.status_byte;
	end

	// each warning gated by its mask bit
	assign alert_next =
		(oc_flag & ~i_warning_alert_mask[pmon_pkg::MASK_INPUT_OVERCURRENT]) |
		(ov_flag & ~i_warning_alert_mask[pmon_pkg::MASK_OVERVOLTAGE]) |
		(uv_flag & ~i_warning_alert_mask[pmon_pkg::MASK_UNDERVOLTAGE]) |
		(op_flag & ~i_warning_alert_mask[pmon_pkg::MASK_OVERPOWER]);

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_status <= '0;
			alert_reg <= 1'b0;
		end else begin
			o_status <= status_next;
			alert_reg <= alert_next;
		end
	end

	// alert pulls the pin low while an unmasked warning stands
	assign o_alert = 1'b0;
	assign o_alert_oe_n = ~alert_reg;

endmodule : power_monitor_warn_limits

// File: pmon_pkg.sv
package pmon_pkg;

	// ==========================================================
	// link addressing
	// bus address of this monitor, arbitrary value
	localparam logic [6:0] DEVICE_ADDR = 7'h40;

	// ==========================================================
	// command codes
	localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
	localparam logic [7:0] CMD_SUPPORTED_FEATURES = 8'h19;
	localparam logic [7:0] CMD_OVERCURRENT_THRESHOLD = 8'h4A;
	localparam logic [7:0] CMD_OVERVOLTAGE_THRESHOLD = 8'h57;
	localparam logic [7:0] CMD_UNDERVOLTAGE_THRESHOLD = 8'h58;
	localparam logic [7:0] CMD_OVERPOWER_THRESHOLD = 8'h6B;

	// ==========================================================
	// register values and writable fields
	localparam logic [7:0] SUPPORTED_FEATURES_VALUE = 8'hB0;
	localparam logic [15:0] OVERCURRENT_RESET = 16'h7FF8;
	localparam logic [15:0] OVERVOLTAGE_RESET = 16'h7FF8;
	localparam logic [15:0] UNDERVOLTAGE_RESET = 16'h0000;
	localparam logic [15:0] OVERPOWER_RESET = 16'hFFF0;
	localparam logic [15:0] VOLTAGE_FIELD_MASK = 16'h7FF8;
	localparam logic [15:0] CURRENT_FIELD_MASK = 16'h7FF8;
	localparam logic [15:0] POWER_FIELD_MASK = 16'hFFF0;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// ==========================================================
	// warning_alert_mask bit positions
	localparam int MASK_INPUT_OVERCURRENT = 0;
	localparam int MASK_OVERVOLTAGE = 1;
	localparam int MASK_UNDERVOLTAGE = 2;
	localparam int MASK_OVERPOWER = 3;

	// ==========================================================
	// status bit positions
	localparam int STATUS_BYTE_NOTA = 0;
	localparam int STATUS_WORD_IOUT = 14;
	localparam int STATUS_WORD_INPUT = 13;
	localparam int STATUS_IOUT_OC_WARN = 5;
	localparam int STATUS_INPUT_OV_WARN = 6;
	localparam int STATUS_INPUT_UV_WARN = 5;
	localparam int STATUS_INPUT_OC_WARN = 1;
	localparam int STATUS_INPUT_OP_WARN = 0;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic [15:0] current_reading;
		logic current_valid;
		logic [15:0] bus_voltage_reading;
		logic voltage_valid;
		logic [15:0] power_reading;
		logic power_valid;
	} meas_s;

	typedef struct packed {
		logic [7:0] status_byte;
		logic [15:0] status_word;
		logic [7:0] status_iout;
		logic [7:0] status_input;
	} status_s;

	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_ADDR = 9'h002,
		ST_ADDR_ACK = 9'h004,
		ST_CMD = 9'h008,
		ST_CMD_ACK = 9'h010,
		ST_WDATA = 9'h020,
		ST_WDATA_ACK = 9'h040,
		ST_RDATA = 9'h080,
		ST_RDATA_ACK = 9'h100
	} link_state_e;

endpackage : pmon_pkg

// File: warn_flag.sv
`timescale 1ns/1ns
module warn_flag (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// control
	input wire logic i_set,
	input wire logic i_clear,
	// state
	output logic o_flag
);

	// ==========================================================
	// sticky flag
	// set wins so a crossing in the clear cycle is kept
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_flag <= 1'b0;
		end else if (i_set) begin
			o_flag <= 1'b1;
		end else if (i_clear) begin
			o_flag <= 1'b0;
		end
	end

endmodule : warn_flag

// File: warn_limits_monitor.sv
`timescale 1ns/1ns
module warn_limits_monitor (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// link and alert pins
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic o_sda,
	input wire logic o_sda_oe_n,
	input wire logic o_alert,
	input wire logic o_alert_oe_n,
	// measurements, mask, status
	input pmon_pkg::meas_s i_meas,
	input wire logic [7:0] i_warning_alert_mask,
	input pmon_pkg::status_s o_status
);
	// ==========================================================
	// helper logic
	logic [7:0] mask_d1_reg;
	logic [7:0] mask_d2_reg;
	logic [3:0] flags;
	logic settled;
	logic live;
	// flags in mask bit order: oc, ov, uv, op
	assign flags = {o_status.status_input[0], o_status.status_input[5],
		o_status.status_input[6], o_status.status_input[1]};
	// mask edits reach the pin one cycle later; settled waits for two stable cycles
	assign settled = (i_warning_alert_mask == mask_d1_reg) && (mask_d1_reg == mask_d2_reg);
	assign live = |(flags & ~i_warning_alert_mask[3:0]);
	always_ff @(posedge i_clk) begin
		mask_d1_reg <= i_warning_alert_mask;
		mask_d2_reg <= mask_d1_reg;
	end
	// run of cycles with the data line pulled; saturates so it never wraps
	logic [7:0] sda_low_cnt;
	always_ff @(posedge i_clk) begin
		if (i_rst || o_sda_oe_n) begin
			sda_low_cnt <= 8'h00;
		end else if (sda_low_cnt != 8'hFF) begin
			sda_low_cnt <= sda_low_cnt + 8'h01;
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	// ==========================================================
	// assertions
	a_alert_unmasked: assert property (settled && live |-> !o_alert_oe_n)
		else $error("alert missing for unmasked warning");
	a_alert_masked: assert property (settled && !live |-> o_alert_oe_n)
		else $error("alert raised with all warnings masked");
	a_summary_or: assert property (o_status.status_byte[0] == |flags[2:0])
		else $error("summary bit differs from warning flags");
	a_oc_mirrors: assert property (o_status.status_iout[5] == flags[0]
		&& o_status.status_word[14] == flags[0])
		else $error("overcurrent bits disagree");
	a_input_summary: assert property (o_status.status_word[13] == |flags)
		else $error("input bit differs from input flags");
	a_oc_cause: assert property ($rose(flags[0]) |-> $past(i_meas.current_valid)
		|| $past(i_meas.current_valid, 2) || $past(i_meas.current_valid, 3))
		else $error("overcurrent flag without current result");
	a_volt_cause: assert property ($rose(flags[1]) || $rose(flags[2])
		|-> $past(i_meas.voltage_valid) || $past(i_meas.voltage_valid, 2)
		|| $past(i_meas.voltage_valid, 3))
		else $error("voltage flag without voltage result");
	a_op_cause: assert property ($rose(flags[3]) |-> $past(i_meas.power_valid)
		|| $past(i_meas.power_valid, 2) || $past(i_meas.power_valid, 3))
		else $error("overpower flag without power result");
	a_open_drain: assert property (!o_sda && !o_alert)
		else $error("open-drain pin value not low");
	// nine bit times at the bench link rate stay well under this
	a_sda_release: assert property (sda_low_cnt < 8'h96)
		else $error("data line held low past one byte");
endmodule : warn_limits_monitor

bind power_monitor_warn_limits warn_limits_monitor warn_limits_monitor_inst (
	.i_clk(i_clk),
	.i_rst(i_rst),
	.i_scl(i_scl),
	.i_sda(i_sda),
	.o_sda(o_sda),
	.o_sda_oe_n(o_sda_oe_n),
	.o_alert(o_alert),
	.o_alert_oe_n(o_alert_oe_n),
	.i_meas(i_meas),
	.i_warning_alert_mask(i_warning_alert_mask),
	.o_status(o_status)
);

// File: pmbus_host_model.sv
`timescale 1ns/1ns
module pmbus_host_model (
	// link pins
	output logic o_scl,
	output logic o_sda_n,
	input wire logic i_sda
);
	// ==========================================================
	// bit level, 125 ns period, clock still between frames
	localparam int Q = 31;
	initial begin
		o_scl = 1'b1;
		o_sda_n = 1'b1;
	end
	task automatic start_cond;
		#Q o_sda_n = 1'b1;
		#Q o_scl = 1'b1;
		#Q o_sda_n = 1'b0;
		#(Q + 1) o_scl = 1'b0;
	endtask : start_cond
	task automatic stop_cond;
		#Q o_sda_n = 1'b0;
		#Q o_scl = 1'b1;
		#Q o_sda_n = 1'b1;
	endtask : stop_cond
	// sample midway through the high phase, device answers after the fall
	task automatic bit_io(input logic b, output logic s);
		#Q o_sda_n = b;
		#Q o_scl = 1'b1;
		#Q s = i_sda;
		#(Q + 1) o_scl = 1'b0;
	endtask : bit_io
	task automatic xfer(input logic [7:0] d, input logic rel, output logic [7:0] q,
		output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], q[i]);
		end
		bit_io(rel, s);
		ack = ~s;
	endtask : xfer
	// ==========================================================
	// word transfers
	// limits go as raw words in the readings' units
	task automatic write_word(input logic [7:0] cmd, input logic [15:0] data, output logic ok);
		logic [7:0] q;
		logic a0, a1, a2, a3;
		start_cond();
		xfer({pmon_pkg::DEVICE_ADDR, 1'b0}, 1'b1, q, a0);
		xfer(cmd, 1'b1, q, a1);
		xfer(data[7:0], 1'b1, q, a2);
		xfer(data[15:8], 1'b1, q, a3);
		stop_cond();
		ok = a0 & a1 & a2 & a3;
	endtask : write_word
	// read word, low byte acked, high byte not
	task automatic read_word(input logic [7:0] cmd, output logic [15:0] data, output logic ok);
		logic a0, a1, a2, a3;
		logic [7:0] q;
		start_cond();
		xfer({pmon_pkg::DEVICE_ADDR, 1'b0}, 1'b1, q, a0);
		xfer(cmd, 1'b1, q, a1);
		start_cond();
		xfer({pmon_pkg::DEVICE_ADDR, 1'b1}, 1'b1, q, a2);
		xfer(8'hFF, 1'b0, data[7:0], a3);
		xfer(8'hFF, 1'b1, data[15:8], a3);
		stop_cond();
		ok = a0 & a1 & a2;
	endtask : read_word
	task automatic send_byte(input logic [7:0] cmd, output logic ok);
		logic [7:0] q;
		logic a0, a1;
		start_cond();
		xfer({pmon_pkg::DEVICE_ADDR, 1'b0}, 1'b1, q, a0);
		xfer(cmd, 1'b1, q, a1);
		stop_cond();
		ok = a0 & a1;
	endtask : send_byte
endmodule : pmbus_host_model

// File: power_monitor_warn_limits_test.sv
`timescale 1ns/1ns
module power_monitor_warn_limits_test;
	typedef struct packed {
		logic [7:0] cmd;
		logic [15:0] wr;
		logic [15:0] rd;
	} reg_row_s;
	typedef struct packed {
		logic [15:0] c;
		logic [15:0] v;
		logic [15:0] p;
		logic [7:0] m;
		logic [39:0] st;
		logic a;
	} meas_row_s;
	// ==========================================================
	// tables
	reg_row_s reg_rows [8] = '{{8'h4A, 16'h1234, 16'h1230}, {8'h4A, 16'hFFFF, 16'h7FF8},
		{8'h57, 16'h8007, 16'h0000}, {8'h58, 16'hFFFF, 16'h7FF8},
		{8'h6B, 16'h000F, 16'h0000}, {8'h6B, 16'hFFFF, 16'hFFF0},
		{8'h19, 16'hFFFF, 16'h00B0}, {8'h20, 16'hFFFF, 16'h0000}};
	reg_row_s rst_rows [4] = '{{8'h4A, 16'h0, 16'h7FF8}, {8'h57, 16'h0, 16'h7FF8},
		{8'h58, 16'h0, 16'h0000}, {8'h6B, 16'h0, 16'hFFF0}};
	reg_row_s lim_rows [4] = '{{8'h4A, 16'h0100, 16'h0}, {8'h57, 16'h4000, 16'h0},
		{8'h58, 16'h1000, 16'h0}, {8'h6B, 16'h8000, 16'h0}};
	// equal magnitude is no crossing, so row three stays quiet
	meas_row_s meas_rows [9] = '{
		{16'hFE00, 16'h2000, 16'h1000, 8'h00, 40'h01_6001_20_02, 1'b0},
		{16'h0101, 16'h2000, 16'h1000, 8'h01, 40'h01_6001_20_02, 1'b1},
		{16'h0100, 16'h2000, 16'h1000, 8'h00, 40'h00_0000_00_00, 1'b1},
		{16'h0000, 16'h4008, 16'h1000, 8'h00, 40'h01_2001_00_40, 1'b0},
		{16'h0000, 16'h4008, 16'h1000, 8'h02, 40'h01_2001_00_40, 1'b1},
		{16'h0000, 16'h0FF8, 16'h1000, 8'h00, 40'h01_2001_00_20, 1'b0},
		{16'h0000, 16'h0FF8, 16'h1000, 8'h04, 40'h01_2001_00_20, 1'b1},
		{16'h0000, 16'h2000, 16'h8010, 8'h00, 40'h00_2000_00_01, 1'b0},
		{16'h0000, 16'h2000, 16'h8010, 8'h08, 40'h00_2000_00_01, 1'b1}};
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic scl, host_sda_n, sda_wire, dev_sda, sda_oe_n, dev_alert, alert_oe_n, ok;
	logic [15:0] rd;
	logic [7:0] mask = 8'h00;
	pmon_pkg::meas_s meas = '0;
	pmon_pkg::status_s status;
	int err_count = 0;
	int n_tests = 0;
	always #5 clk = ~clk;
	// pull-up on the data wire
	assign sda_wire = host_sda_n & (sda_oe_n | dev_sda);

	pmbus_host_model host_inst (.o_scl(scl), .o_sda_n(host_sda_n), .i_sda(sda_wire));
	power_monitor_warn_limits power_monitor_warn_limits_inst (.i_clk(clk), .i_rst(rst),
		.i_scl(scl), .i_sda(sda_wire), .o_sda(dev_sda), .o_sda_oe_n(sda_oe_n),
		.o_alert(dev_alert), .o_alert_oe_n(alert_oe_n), .i_meas(meas),
		.i_warning_alert_mask(mask), .o_status(status));

	task automatic check(input logic [47:0] seen, input logic [47:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : conclude
	// one result of each kind, mask set alongside
	task automatic pulse(input logic [15:0] c, v, p, input logic [7:0] m);
		@(posedge clk);
		mask <= m;
		meas <= {c, 1'b1, v, 1'b1, p, 1'b1};
		@(posedge clk);
		meas <= {c, 1'b0, v, 1'b0, p, 1'b0};
		repeat (3) @(posedge clk);
		#1;
	endtask : pulse
	task automatic do_reset;
		@(posedge clk);
		rst <= 1'b1;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : do_reset

	initial begin
		repeat (100000) @(posedge clk);
		err_count++;
		conclude();
	end

	// ==========================================================
	// main sequence
	initial begin
		do_reset();
		foreach (reg_rows[i]) begin
			host_inst.write_word(reg_rows[i].cmd, reg_rows[i].wr, ok);
			check(48'(ok), 48'h1);
			host_inst.read_word(reg_rows[i].cmd, rd, ok);
			check(48'(rd), 48'(reg_rows[i].rd));
		end
		$display("register rows done");
		// second reset while limits hold written values
		do_reset();
		check(48'({status, alert_oe_n}), 48'h1);
		foreach (rst_rows[i]) begin
			host_inst.read_word(rst_rows[i].cmd, rd, ok);
			check(48'(rd), 48'(rst_rows[i].rd));
		end
		$display("reset test done");
		foreach (lim_rows[i]) begin
			host_inst.write_word(lim_rows[i].cmd, lim_rows[i].wr, ok);
		end
		foreach (meas_rows[i]) begin
			host_inst.send_byte(pmon_pkg::CMD_CLEAR_FAULTS, ok);
			pulse(meas_rows[i].c, meas_rows[i].v, meas_rows[i].p, meas_rows[i].m);
			check(48'({status, alert_oe_n}), 48'({meas_rows[i].st, meas_rows[i].a}));
		end
		$display("measurement rows done");
		host_inst.send_byte(pmon_pkg::CMD_CLEAR_FAULTS, ok);
		check(48'({status, alert_oe_n}), 48'h1);
		pulse(16'hFE00, 16'h2000, 16'h1000, 8'h00);
		check(48'({status, alert_oe_n}), 48'({40'h01_6001_20_02, 1'b0}));
		$display("re-arm test done");
		conclude();
	end
endmodule : power_monitor_warn_limits_test
